// *** rtl/fpu_control_status_regs.sv ***
// control and status registers of the single-precision fpu
// ****************************************
// Notes on behaviour
// ****************************************
// Notes on behaviour
// - second access field: 0 deny+fault, 1 privileged only, 3 full, 2 reserved
// - unprivileged fp access with field 1 raises a no-coprocessor fault
// - auto-preserve bit 31 set: fp instruction sets core control bit 2
// - auto-preserve on: save context on exception entry unless bit 30 set, restore on exit
// - bit 30 enables lazy preservation
// - bit 0 reads 1 while frame allocated and save deferred
// - bit 8 records debug monitor readiness at frame allocation
// - bits 6 and 5 record bus and memory fault readiness at allocation
// - bit 4 records hard fault readiness at allocation
// - bit 3 records thread mode at allocation
// - bit 1 records unprivileged level at allocation
// - context address holds bits 31..3 of reserved register space
// - comparisons update flags in bits 31..28 of status/control
// - bit 26 selects alternative half-precision format
// - bit 25 selects default NaN result
// - bit 24 enables flush-to-zero
// - bits 23..22 select rounding mode
// - sticky exception bits set on event, cleared only by writing 0
// - default register holds defaults for bits 26..22
// - unit disabled out of reset until access fields enabled
// - privilege register accessible only in privileged mode
`timescale 1ns/10ps
`default_nettype none
module fpu_control_status_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic regPrivileged,
  output logic [31:0] regRdata,
  input wire logic fpInstr,
  input wire logic fpPrivileged,
  input wire logic fpCompare,
  input wire logic [3:0] fpFlags,
  input wire logic [5:0] fpExceptions,
  input wire logic frameAlloc,
  input wire logic [31:0] frameAddr,
  input wire logic monReady,
  input wire logic busReady,
  input wire logic memReady,
  input wire logic hardReady,
  input wire logic threadMode,
  input wire logic userLevel,
  input wire logic lazySaveDone,
  input wire logic excReturn,
  output logic fpAllow,
  output logic noCoprocFault,
  output logic setCtrlFpActive,
  output logic saveContext,
  output logic restoreContext,
  output logic altHalfPrecision,
  output logic defaultNanMode,
  output logic flushToZero,
  output logic [1:0] roundingSelect
);
  // ****************************************
  // reset release
  // ****************************************
  logic rstSync1_q;
  logic rstSync2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  wire logic rstIn_n;
  assign rstIn_n = rstSync2_q;

  // ****************************************
  // register decode
  // ****************************************
  logic [31:0] priv_q;
  logic [31:0] ctxCtl_q;
  logic [31:0] ctxAddr_q;
  logic [31:0] status_q;
  logic [31:0] defaults_q;
  wire logic wrPriv;
  wire logic wrCtl;
  wire logic wrAddr;
  wire logic wrStatus;
  wire logic wrDefault;
  // privileged only: user writes dropped, user reads return zero
  assign wrPriv = regWrite && regPrivileged && (regAddr == fpu_csr_pkg::OFF_PRIV);
  assign wrCtl = regWrite && (regAddr == fpu_csr_pkg::OFF_CTXCTL);
  assign wrAddr = regWrite && (regAddr == fpu_csr_pkg::OFF_CTXADDR);
  assign wrStatus = regWrite && (regAddr == fpu_csr_pkg::OFF_STATUS);
  assign wrDefault = regWrite && (regAddr == fpu_csr_pkg::OFF_DEFAULT);

  // ****************************************
  // access checking
  // ****************************************
  wire logic [1:0] secondAcc;
  wire logic [1:0] firstAcc;
  wire logic allowFirst;
  wire logic faultFirst;
  wire logic allowSecond;
  wire logic faultSecond;
  assign secondAcc = priv_q[fpu_csr_pkg::SECOND_ACC_LSB +: 2];
  assign firstAcc = priv_q[fpu_csr_pkg::FIRST_ACC_LSB +: 2];
  access_check uFirst (
    .accField(firstAcc),
    .privileged(fpPrivileged),
    .request(fpInstr),
    .allow(allowFirst),
    .fault(faultFirst)
  );
  access_check uSecond (
    .accField(secondAcc),
    .privileged(fpPrivileged),
    .request(fpInstr),
    .allow(allowSecond),
    .fault(faultSecond)
  );
  // instruction runs only when both fields permit it
  wire logic fpGo;
  wire logic fpFault;
  assign fpGo = allowFirst && allowSecond;
  assign fpFault = faultFirst || faultSecond;

  // ****************************************
  // context control
  // ****************************************
  wire logic autoEn;
  wire logic lazyEn;
  wire logic lazyAct;
  assign autoEn = ctxCtl_q[fpu_csr_pkg::AUTO_PRESERVE_BIT];
  assign lazyEn = ctxCtl_q[fpu_csr_pkg::LAZY_PRESERVE_BIT];
  assign lazyAct = ctxCtl_q[fpu_csr_pkg::LAZY_ACTIVE_BIT];
  wire logic [31:0] allocCapture;
  assign allocCapture = (32'h1 << fpu_csr_pkg::MON_READY_BIT) & {32{monReady}}
    | (32'h1 << fpu_csr_pkg::BUS_READY_BIT) & {32{busReady}}
    | (32'h1 << fpu_csr_pkg::MEM_READY_BIT) & {32{memReady}}
    | (32'h1 << fpu_csr_pkg::HARD_READY_BIT) & {32{hardReady}}
    | (32'h1 << fpu_csr_pkg::THREAD_BIT) & {32{threadMode}}
    | (32'h1 << fpu_csr_pkg::USER_BIT) & {32{userLevel}}
    | (32'h1 << fpu_csr_pkg::LAZY_ACTIVE_BIT) & {32{lazyEn}};
  wire logic [31:0] allocKeep;
  assign allocKeep = 32'hC000_0000;
  logic [31:0] ctxCtl_d;
  always_comb begin
    ctxCtl_d = ctxCtl_q;
    if (wrCtl) begin
      ctxCtl_d = regWdata & fpu_csr_pkg::CTXCTL_MASK;
    end
    if (frameAlloc && autoEn) begin
      ctxCtl_d = (ctxCtl_q & allocKeep) | allocCapture;
    end else if (lazySaveDone || (fpGo && lazyAct)) begin
      // deferred save happens now: frame no longer pending
      ctxCtl_d[fpu_csr_pkg::LAZY_ACTIVE_BIT] = 1'b0;
    end
  end
  // frame address latched at allocation, low three bits forced zero
  logic [31:0] ctxAddr_d;
  assign ctxAddr_d = (frameAlloc && autoEn) ? (frameAddr & fpu_csr_pkg::CTXADDR_MASK)
    : wrAddr ? (regWdata & fpu_csr_pkg::CTXADDR_MASK) : ctxAddr_q;

  // ****************************************
  // status/control with sticky exceptions
  // ****************************************
  wire logic [31:0] stickyIn;
  assign stickyIn = {24'h00_0000, fpExceptions[5], 2'b00, fpExceptions[4:0]};
  logic [31:0] status_d;
  always_comb begin
    status_d = status_q;
    if (wrStatus) begin
      status_d = regWdata & fpu_csr_pkg::STATUS_MASK;
    end
    if (frameAlloc && autoEn) begin
      // new context starts from the default controls
      status_d[26:22] = defaults_q[26:22];
    end
    if (fpGo && fpCompare) begin
      status_d[fpu_csr_pkg::FLAG_LSB +: 4] = fpFlags;
    end
    if (fpGo) begin
      // set beats a same-cycle clear by software
      status_d = status_d | stickyIn;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      priv_q <= fpu_csr_pkg::PRIV_RESET;
      ctxCtl_q <= fpu_csr_pkg::CTXCTL_RESET;
      ctxAddr_q <= fpu_csr_pkg::CTXADDR_RESET;
      status_q <= fpu_csr_pkg::STATUS_RESET;
      defaults_q <= fpu_csr_pkg::DEFAULT_RESET;
    end else begin
      priv_q <= wrPriv ? (regWdata & fpu_csr_pkg::PRIV_MASK) : priv_q;
      ctxCtl_q <= ctxCtl_d;
      ctxAddr_q <= ctxAddr_d;
      status_q <= status_d;
      defaults_q <= wrDefault ? (regWdata & fpu_csr_pkg::DEFAULT_MASK) : defaults_q;
    end
  end

  // ****************************************
  // read port and outputs
  // ****************************************
  logic [31:0] rdMux;
  always_comb begin
    case (regAddr)
      fpu_csr_pkg::OFF_PRIV: rdMux = regPrivileged ? priv_q : 32'h0000_0000;
      fpu_csr_pkg::OFF_CTXCTL: rdMux = ctxCtl_q;
      fpu_csr_pkg::OFF_CTXADDR: rdMux = ctxAddr_q;
      fpu_csr_pkg::OFF_STATUS: rdMux = status_q;
      fpu_csr_pkg::OFF_DEFAULT: rdMux = defaults_q;
      default: rdMux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      regRdata <= 32'h0000_0000;
      fpAllow <= 1'b0;
      noCoprocFault <= 1'b0;
      setCtrlFpActive <= 1'b0;
      saveContext <= 1'b0;
      restoreContext <= 1'b0;
      altHalfPrecision <= 1'b0;
      defaultNanMode <= 1'b0;
      flushToZero <= 1'b0;
      roundingSelect <= 2'b00;
    end else begin
      regRdata <= regRead ? rdMux : 32'h0000_0000;
      fpAllow <= fpGo;
      noCoprocFault <= fpFault;
      setCtrlFpActive <= fpGo && autoEn;
      // lazy mode defers the save until the next fp instruction
      saveContext <= frameAlloc && autoEn && !lazyEn;
      restoreContext <= excReturn && autoEn;
      altHalfPrecision <= status_d[fpu_csr_pkg::ALT_HALF_BIT];
      defaultNanMode <= status_d[fpu_csr_pkg::DEF_NAN_BIT];
      flushToZero <= status_d[fpu_csr_pkg::FLUSH_BIT];
      roundingSelect <= status_d[fpu_csr_pkg::ROUND_LSB +: 2];
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_deny_fault;
    @(posedge clk) disable iff (!rstIn_n)
    (fpInstr && (secondAcc == fpu_csr_pkg::ACC_DENIED)) |=> noCoprocFault && !fpAllow;
  endproperty
  a_deny_fault: assert property (p_deny_fault) else $error("denied access not faulted");
  property p_user_fault;
    @(posedge clk) disable iff (!rstIn_n)
    (fpInstr && !fpPrivileged && (secondAcc == fpu_csr_pkg::ACC_PRIV)) |=> noCoprocFault;
  endproperty
  a_user_fault: assert property (p_user_fault) else $error("user access not faulted");
  property p_ctrl_set;
    @(posedge clk) disable iff (!rstIn_n)
    setCtrlFpActive |-> $past(autoEn) && $past(fpInstr);
  endproperty
  a_ctrl_set: assert property (p_ctrl_set) else $error("control bit set without cause");
  property p_save;
    @(posedge clk) disable iff (!rstIn_n)
    saveContext |-> $past(frameAlloc) && !$past(lazyEn);
  endproperty
  a_save: assert property (p_save) else $error("save without allocation");
  property p_lazy;
    @(posedge clk) disable iff (!rstIn_n)
    (frameAlloc && autoEn && lazyEn) |=> lazyAct;
  endproperty
  a_lazy: assert property (p_lazy) else $error("lazy save not marked");
  property p_thread;
    @(posedge clk) disable iff (!rstIn_n)
    (frameAlloc && autoEn) |=> ctxCtl_q[fpu_csr_pkg::THREAD_BIT] == $past(threadMode);
  endproperty
  a_thread: assert property (p_thread) else $error("thread mode not captured");
  property p_addr;
    @(posedge clk) disable iff (!rstIn_n)
    ctxAddr_q[2:0] == 3'b000;
  endproperty
  a_addr: assert property (p_addr) else $error("address low bits not zero");
  sequence s_exc;
    fpGo && (fpExceptions != 6'h00) && !frameAlloc;
  endsequence
  property p_sticky;
    @(posedge clk) disable iff (!rstIn_n)
    s_exc |=> (status_q[4:0] & $past(fpExceptions[4:0])) == $past(fpExceptions[4:0]);
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky bit lost");
  property p_reserved;
    @(posedge clk) disable iff (!rstIn_n)
    (status_q & ~fpu_csr_pkg::STATUS_MASK) == 32'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
  sequence s_alloc;
    frameAlloc && autoEn;
  endsequence
  property p_no_save;
    @(posedge clk) disable iff (!rstIn_n)
    (frameAlloc && autoEn && lazyEn) |=> !saveContext;
  endproperty
  a_no_save: assert property (p_no_save) else $error("save not deferred");
  property p_mon;
    @(posedge clk) disable iff (!rstIn_n)
    s_alloc |=> ctxCtl_q[fpu_csr_pkg::MON_READY_BIT] == $past(monReady);
  endproperty
  a_mon: assert property (p_mon) else $error("monitor ready lost");
  property p_busmem;
    @(posedge clk) disable iff (!rstIn_n)
    s_alloc |=> (ctxCtl_q[fpu_csr_pkg::BUS_READY_BIT] == $past(busReady)) &&
      (ctxCtl_q[fpu_csr_pkg::MEM_READY_BIT] == $past(memReady));
  endproperty
  a_busmem: assert property (p_busmem) else $error("fault ready lost");
  property p_hard;
    @(posedge clk) disable iff (!rstIn_n)
    s_alloc |=> ctxCtl_q[fpu_csr_pkg::HARD_READY_BIT] == $past(hardReady);
  endproperty
  a_hard: assert property (p_hard) else $error("hard fault ready lost");
  property p_user_lvl;
    @(posedge clk) disable iff (!rstIn_n)
    s_alloc |=> ctxCtl_q[fpu_csr_pkg::USER_BIT] == $past(userLevel);
  endproperty
  a_user_lvl: assert property (p_user_lvl) else $error("user level lost");
  property p_flags;
    @(posedge clk) disable iff (!rstIn_n)
    (fpGo && fpCompare) |=> status_q[fpu_csr_pkg::FLAG_LSB +: 4] == $past(fpFlags);
  endproperty
  a_flags: assert property (p_flags) else $error("flags not updated");
  property p_modes;
    @(posedge clk) disable iff (!rstIn_n)
    {altHalfPrecision, defaultNanMode, flushToZero, roundingSelect} ==
      status_q[fpu_csr_pkg::ROUND_LSB +: 5];
  endproperty
  a_modes: assert property (p_modes) else $error("mode out");
  property p_defaults;
    @(posedge clk) disable iff (!rstIn_n)
    s_alloc |=> status_q[26:22] == $past(defaults_q[26:22]);
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not loaded");
  property p_priv_guard;
    @(posedge clk) disable iff (!rstIn_n)
    (regWrite && !regPrivileged && (regAddr == fpu_csr_pkg::OFF_PRIV)) |=> $stable(priv_q);
  endproperty
  a_priv_guard: assert property (p_priv_guard) else $error("user write landed");
  property p_ctl_resv;
    @(posedge clk) disable iff (!rstIn_n)
    (ctxCtl_q & ~fpu_csr_pkg::CTXCTL_MASK) == 32'h0000_0000;
  endproperty
  a_ctl_resv: assert property (p_ctl_resv) else $error("reserved ctl bit set");
endmodule // fpu_control_status_regs
`default_nettype wire

// *** rtl/fpu_csr_pkg.sv ***
// package of offsets, field positions and reset values for the fpu control registers
package fpu_csr_pkg;
  // register offsets
  localparam logic [11:0] OFF_PRIV = 12'h000;
  localparam logic [11:0] OFF_CTXCTL = 12'h0_04;
  localparam logic [11:0] OFF_CTXADDR = 12'h0_08;
  localparam logic [11:0] OFF_STATUS = 12'h0_0C;
  localparam logic [11:0] OFF_DEFAULT = 12'h0_10;
  localparam logic [11:0] OFF_CTRLSTAT = 12'h0_14;
  // privilege register: both coprocessor access fields
  localparam int FIRST_ACC_LSB = 20;
  localparam int SECOND_ACC_LSB = 22;
  localparam logic [1:0] ACC_DENIED = 2'h0;
  localparam logic [1:0] ACC_PRIV = 2'h1;
  localparam logic [1:0] ACC_RESERVED = 2'h2;
  localparam logic [1:0] ACC_FULL = 2'h3;
  // context control fields
  localparam int AUTO_PRESERVE_BIT = 31;
  localparam int LAZY_PRESERVE_BIT = 30;
  localparam int MON_READY_BIT = 8;
  localparam int BUS_READY_BIT = 6;
  localparam int MEM_READY_BIT = 5;
  localparam int HARD_READY_BIT = 4;
  localparam int THREAD_BIT = 3;
  localparam int USER_BIT = 1;
  localparam int LAZY_ACTIVE_BIT = 0;
  localparam logic [31:0] CTXCTL_MASK = 32'hC000_017B;
  localparam logic [31:0] CTXADDR_MASK = 32'hFFFF_FFF8;
  // status/control fields
  localparam int FLAG_LSB = 28;
  localparam int ALT_HALF_BIT = 26;
  localparam int DEF_NAN_BIT = 25;
  localparam int FLUSH_BIT = 24;
  localparam int ROUND_LSB = 22;
  localparam logic [31:0] STATUS_MASK = 32'hF7C0_009F;
  localparam logic [31:0] DEFAULT_MASK = 32'h07C0_0000;
  localparam logic [31:0] PRIV_MASK = 32'h00F0_0000;
  // sticky bit order: input denormal at 7, then inexact..invalid at 4..0
  localparam int STICKY_N = 6;
  // reset values
  localparam logic [31:0] PRIV_RESET = 32'h0000_0000;
  localparam logic [31:0] CTXCTL_RESET = 32'hC000_0000;
  localparam logic [31:0] CTXADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] DEFAULT_RESET = 32'h0000_0000;
endpackage

// *** rtl/access_check.sv ***
// access decode for one coprocessor access field
`timescale 1ns/10ps
`default_nettype none
module access_check (
  input wire logic [1:0] accField,
  input wire logic privileged,
  input wire logic request,
  output logic allow,
  output logic fault
);
  // reserved code treated as denial, the safest reading of unpredictable
  wire logic permitted;
  assign permitted = (accField == fpu_csr_pkg::ACC_FULL) ||
                     ((accField == fpu_csr_pkg::ACC_PRIV) && privileged);
  assign allow = request && permitted;
  assign fault = request && !permitted;
endmodule // access_check
`default_nettype wire

// *** testbench/core_model.sv ***
// behavioural processor core driving the instruction and exception side
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input wire logic clk,
  output logic fpInstr,
  output logic fpPrivileged,
  output logic fpCompare,
  output logic [3:0] fpFlags,
  output logic [5:0] fpExceptions,
  output logic frameAlloc,
  output logic [31:0] frameAddr,
  output logic [5:0] levels,
  output logic lazySaveDone,
  output logic excReturn
);
  initial begin
    fpInstr = 1'b0;
    fpPrivileged = 1'b0;
    fpCompare = 1'b0;
    fpFlags = 4'h0;
    fpExceptions = 6'h00;
    frameAlloc = 1'b0;
    frameAddr = 32'h0000_0000;
    levels = 6'h00;
    lazySaveDone = 1'b0;
    excReturn = 1'b0;
  end
  // qualifiers go stale after the pulse, so they are inverted, not held
  task automatic issue(input logic p, input logic c, input logic [3:0] f, input logic [5:0] x);
    @(posedge clk);
    fpInstr <= 1'b1;
    fpPrivileged <= p;
    fpCompare <= c;
    fpFlags <= f;
    fpExceptions <= x;
    @(posedge clk);
    fpInstr <= 1'b0;
    fpPrivileged <= ~p;
    fpCompare <= ~c;
    fpFlags <= ~f;
    fpExceptions <= ~x;
  endtask
  // levels {monitor,bus,mem,hard,thread,user} ride with the allocation
  task automatic alloc(input logic [31:0] a, input logic [5:0] lv);
    @(posedge clk);
    frameAlloc <= 1'b1;
    frameAddr <= a;
    levels <= lv;
    @(posedge clk);
    frameAlloc <= 1'b0;
    frameAddr <= ~a;
    levels <= ~lv;
  endtask
  task automatic pulse(input logic done, input logic ret);
    @(posedge clk);
    lazySaveDone <= done;
    excReturn <= ret;
    @(posedge clk);
    lazySaveDone <= 1'b0;
    excReturn <= 1'b0;
  endtask
endmodule // core_model
`default_nettype wire

// *** testbench/fpu_control_status_regs_tb.sv ***
// self-checking bench for the fpu control and status registers
`timescale 1ns/10ps
`default_nettype none
module fpu_control_status_regs_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWdata = 32'h0000_0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic regPrivileged = 1'b0;
  logic [31:0] exp;
  logic [4:0] md;
  int failCount = 0;
  int nCompared = 0;
  wire [31:0] regRdata;
  wire [31:0] frameAddr;
  wire [5:0] levels;
  wire [5:0] fpExceptions;
  wire [3:0] fpFlags;
  wire [1:0] roundingSelect;
  wire fpInstr, fpPrivileged, fpCompare, frameAlloc, lazySaveDone, excReturn;
  wire fpAllow, noCoprocFault, setCtrlFpActive, saveContext, restoreContext;
  wire altHalfPrecision, defaultNanMode, flushToZero;

  always #2.5 clk = ~clk;

  core_model core_model_inst (.clk(clk), .fpInstr(fpInstr), .fpPrivileged(fpPrivileged),
    .fpCompare(fpCompare), .fpFlags(fpFlags), .fpExceptions(fpExceptions),
    .frameAlloc(frameAlloc), .frameAddr(frameAddr), .levels(levels),
    .lazySaveDone(lazySaveDone), .excReturn(excReturn));

  fpu_control_status_regs fpu_control_status_regs_inst (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regPrivileged(regPrivileged), .regRdata(regRdata), .fpInstr(fpInstr),
    .fpPrivileged(fpPrivileged), .fpCompare(fpCompare), .fpFlags(fpFlags),
    .fpExceptions(fpExceptions), .frameAlloc(frameAlloc), .frameAddr(frameAddr),
    .monReady(levels[5]), .busReady(levels[4]), .memReady(levels[3]),
    .hardReady(levels[2]), .threadMode(levels[1]), .userLevel(levels[0]),
    .lazySaveDone(lazySaveDone), .excReturn(excReturn), .fpAllow(fpAllow),
    .noCoprocFault(noCoprocFault), .setCtrlFpActive(setCtrlFpActive),
    .saveContext(saveContext), .restoreContext(restoreContext),
    .altHalfPrecision(altHalfPrecision), .defaultNanMode(defaultNanMode),
    .flushToZero(flushToZero), .roundingSelect(roundingSelect));

  // ****************************************
  // bus and check tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    nCompared++;
    if (got !== e) begin
      failCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic p);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regPrivileged <= p;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rdchk(input logic [11:0] a, input logic p, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regPrivileged <= p;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(regRdata, e);
  endtask
  // e = {allow, fault, control bit set}
  task automatic fpchk(input logic p, input logic [2:0] e);
    core_model_inst.issue(p, 1'b0, 4'h0, 6'h00);
    #1;
    chk({29'h0000_0000, fpAllow, noCoprocFault, setCtrlFpActive}, {29'h0000_0000, e});
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    #(5000 * 5);
    failCount++;
    results();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(fpu_csr_pkg::OFF_PRIV, 1'b1, fpu_csr_pkg::PRIV_RESET);
    rdchk(fpu_csr_pkg::OFF_CTXCTL, 1'b1, fpu_csr_pkg::CTXCTL_RESET);
    rdchk(fpu_csr_pkg::OFF_STATUS, 1'b1, 32'h0000_0000);
    wr(12'h020, 32'hFFFF_FFFF, 1'b1);
    rdchk(12'h020, 1'b1, 32'h0000_0000);
    fpchk(1'b1, 3'h2);
    $display("test reset done");
    for (int v = 0; v < 4; v++) begin
      wr(fpu_csr_pkg::OFF_PRIV, 32'(v * 5) << 20, 1'b1);
      fpchk(1'b0, (v == 3) ? 3'h5 : 3'h2);
      fpchk(1'b1, (v == 1 || v == 3) ? 3'h5 : 3'h2);
    end
    wr(fpu_csr_pkg::OFF_PRIV, 32'h0030_0000, 1'b1);
    fpchk(1'b1, 3'h2);
    wr(fpu_csr_pkg::OFF_PRIV, 32'h00F0_0000, 1'b0);
    rdchk(fpu_csr_pkg::OFF_PRIV, 1'b1, 32'h0030_0000);
    wr(fpu_csr_pkg::OFF_PRIV, 32'hFFFF_FFFF, 1'b1);
    rdchk(fpu_csr_pkg::OFF_PRIV, 1'b0, 32'h0000_0000);
    rdchk(fpu_csr_pkg::OFF_PRIV, 1'b1, fpu_csr_pkg::PRIV_MASK);
    $display("test access done");
    wr(fpu_csr_pkg::OFF_CTXCTL, 32'hFFFF_FFFF, 1'b1);
    rdchk(fpu_csr_pkg::OFF_CTXCTL, 1'b1, fpu_csr_pkg::CTXCTL_MASK);
    wr(fpu_csr_pkg::OFF_CTXCTL, 32'h0000_0000, 1'b1);
    fpchk(1'b0, 3'h4);
    wr(fpu_csr_pkg::OFF_CTXADDR, 32'hFFFF_FFFF, 1'b1);
    rdchk(fpu_csr_pkg::OFF_CTXADDR, 1'b1, 32'hFFFF_FFF8);
    wr(fpu_csr_pkg::OFF_DEFAULT, 32'hFFFF_FFFF, 1'b1);
    rdchk(fpu_csr_pkg::OFF_DEFAULT, 1'b1, fpu_csr_pkg::DEFAULT_MASK);
    wr(fpu_csr_pkg::OFF_STATUS, 32'hFFFF_FFFF, 1'b1);
    rdchk(fpu_csr_pkg::OFF_STATUS, 1'b1, fpu_csr_pkg::STATUS_MASK);
    for (int m = 0; m < 4; m++) begin
      md = {m[0], m[1], m[0] ^ m[1], m[1:0]};
      wr(fpu_csr_pkg::OFF_STATUS, {5'h00, md, 22'h00_0000}, 1'b1);
      @(posedge clk);
      #1;
      chk({27'h000_0000, altHalfPrecision, defaultNanMode, flushToZero, roundingSelect},
          {27'h000_0000, md});
    end
    $display("test modes done");
    wr(fpu_csr_pkg::OFF_STATUS, 32'h0000_0000, 1'b1);
    exp = 32'h0000_0000;
    for (int i = 0; i < 6; i++) begin
      core_model_inst.issue(1'b0, 1'b1, 4'(i + 9), 6'(1 << i));
      exp = {4'(i + 9), exp[27:0]} | (32'h0000_0001 << ((i == 5) ? 7 : i));
      rdchk(fpu_csr_pkg::OFF_STATUS, 1'b1, exp);
    end
    core_model_inst.issue(1'b0, 1'b0, 4'h0, 6'h00);
    rdchk(fpu_csr_pkg::OFF_STATUS, 1'b1, exp);
    wr(fpu_csr_pkg::OFF_STATUS, 32'h0000_0000, 1'b1);
    rdchk(fpu_csr_pkg::OFF_STATUS, 1'b1, 32'h0000_0000);
    $display("test status done");
    wr(fpu_csr_pkg::OFF_CTXCTL, 32'hC000_0000, 1'b1);
    wr(fpu_csr_pkg::OFF_DEFAULT, 32'h0580_0000, 1'b1);
    core_model_inst.alloc(32'h2000_1237, 6'h2D);
    #1;
    chk({31'h0000_0000, saveContext}, 32'h0000_0000);
    rdchk(fpu_csr_pkg::OFF_CTXCTL, 1'b1, 32'hC000_0133);
    rdchk(fpu_csr_pkg::OFF_CTXADDR, 1'b1, 32'h2000_1230);
    rdchk(fpu_csr_pkg::OFF_STATUS, 1'b1, 32'h0580_0000);
    core_model_inst.pulse(1'b1, 1'b0);
    rdchk(fpu_csr_pkg::OFF_CTXCTL, 1'b1, 32'hC000_0132);
    wr(fpu_csr_pkg::OFF_CTXCTL, 32'h8000_0000, 1'b1);
    core_model_inst.alloc(32'h0000_0FFC, 6'h12);
    #1;
    chk({31'h0000_0000, saveContext}, 32'h0000_0001);
    rdchk(fpu_csr_pkg::OFF_CTXCTL, 1'b1, 32'h8000_0048);
    core_model_inst.pulse(1'b0, 1'b1);
    #1;
    chk({31'h0000_0000, restoreContext}, 32'h0000_0001);
    $display("test frame done");
    results();
  end
endmodule // fpu_control_status_regs_tb
`default_nettype wire
